// ===== rtl/dpg_pkg.sv
// Shared constants for the dual port GPIO configuration block.
package dpg_pkg;
    // Byte widths and pin counts.
    localparam int unsigned PORT_W = 8;
    localparam int unsigned PIN_N  = 16;
    localparam int unsigned SYNC_N = 2;

    // Register addresses, decoded on every register page.
    localparam logic [7:0] ADDR_FIRST_LATCH   = 8'h80;
    localparam logic [7:0] ADDR_SECOND_LATCH  = 8'h90;
    localparam logic [7:0] ADDR_FIRST_DRIVE   = 8'hA4;
    localparam logic [7:0] ADDR_SECOND_DRIVE  = 8'hA5;
    localparam logic [7:0] ADDR_FIRST_BYPASS  = 8'hD4;
    localparam logic [7:0] ADDR_SECOND_BYPASS = 8'hD5;
    localparam logic [7:0] ADDR_FIRST_ANALOG  = 8'hF1;
    localparam logic [7:0] ADDR_SECOND_ANALOG = 8'hF2;

    // Bit addressing: upper five bits pick the byte, lower three the bit.
    localparam int unsigned BIT_SEL_LSB = 3;

    // Values after reset.
    localparam logic [7:0] RST_LATCH  = 8'hFF;
    localparam logic [7:0] RST_ANALOG = 8'hFF;
    localparam logic [7:0] RST_DRIVE  = 8'h00;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ===== rtl/dpg_pin_if.sv
// Carries raw pin levels to the synchroniser and the clean levels back.
`timescale 1ns/1ns
interface dpg_pin_if #(
    parameter int unsigned WIDTH = 16
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] level;

    modport sync_side (input raw, output level);
    modport core_side (output raw, input level);
endinterface

// ===== rtl/dpg_sync.sv
// Two-stage synchroniser for the package pin inputs.
`timescale 1ns/1ns
module dpg_sync
    import dpg_pkg::*;
#(
    parameter int unsigned WIDTH = 16
)
(
    // Clock and reset.
    input  wire logic  clk,
    input  wire logic  sys_rst,
    // Pin levels in and out.
    dpg_pin_if.sync_side pins
);
    typedef struct packed {
        logic [WIDTH-1:0] first_stage;
        logic [WIDTH-1:0] second_stage;
    } dpg_sync_type;

    dpg_sync_type sync_reg;
    dpg_sync_type sync_next;

    // Refuse widths the synchroniser cannot serve.
    if (WIDTH < 1) begin : g_bad_width
        $error("dpg_sync: WIDTH must be at least one.");
    end

    // The first stage is read only by the second stage.
    always_comb
    begin
        sync_next.first_stage  = pins.raw;
        sync_next.second_stage = sync_reg.first_stage;
    end

    // Pins reset low in both stages.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    // Clean levels leave from the second stage.
    assign pins.level = sync_reg.second_stage;
endmodule

// ===== rtl/dpg_gpio.sv
// Configuration registers and pin drive logic for two 8-bit GPIO ports.
//
// Behaviour
// - Writing a data register stores each bit in the pin output latch.
// - Plain data register reads return sampled pin levels, not latch contents.
// - Bit n of every port register controls pin n of that port.
// - Analog pins lose weak pullup, digital driver and digital receiver.
// - Input-mode bit 0 selects analog, 1 selects digital operation.
// - Output-mode bit is ignored while the pin is analog.
// - Output-mode bit 0 gives open-drain, 1 gives push-pull.
// - Skip bit 1 tells the crossbar to pass over that pin.
// - Data registers support single-bit and whole-byte access.
// - Every port register decodes at a fixed address on every page.
// - Read-modify-write reads of a data register return the latch value.
// - Data reads return pin levels even for crossbar-assigned pins.
// - Serial bus data and clock pins always drive open-drain.
`timescale 1ns/1ns
module dpg_gpio
    import dpg_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Byte access from the processor core.
    input  wire logic [7:0]          sfr_addr,
    input  wire logic [PORT_W-1:0]   sfr_wdata,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    input  wire logic                sfr_rmw,
    // Bit access from the processor core.
    input  wire logic [7:0]          sfr_bit_addr,
    input  wire logic                sfr_bit_wdata,
    input  wire logic                sfr_bit_wr,
    input  wire logic                sfr_bit_rd,
    // Read answer to the processor core.
    output logic [PORT_W-1:0]        sfr_rdata,
    output logic                     sfr_hit,
    // Crossbar side.
    input  wire logic [PIN_N-1:0]    od_force,
    output logic [PIN_N-1:0]         xbar_skip,
    // Package pins.
    input  wire logic [PIN_N-1:0]    pin_in,
    output logic [PIN_N-1:0]         pin_out,
    output logic [PIN_N-1:0]         pin_oe,
    output logic [PIN_N-1:0]         pin_pullup_en,
    output logic [PIN_N-1:0]         pin_rx_en
);
    typedef struct packed {
        logic [PORT_W-1:0] first_port_latch;
        logic [PORT_W-1:0] second_port_latch;
        logic [PORT_W-1:0] first_port_drive_type;
        logic [PORT_W-1:0] second_port_drive_type;
        logic [PORT_W-1:0] first_port_crossbar_bypass;
        logic [PORT_W-1:0] second_port_crossbar_bypass;
        logic [PORT_W-1:0] first_port_analog_select;
        logic [PORT_W-1:0] second_port_analog_select;
        logic [PORT_W-1:0] rd_data;
        logic              rd_hit;
        logic [PIN_N-1:0]  drv_out;
        logic [PIN_N-1:0]  drv_oe;
        logic [PIN_N-1:0]  pullup_en;
        logic [PIN_N-1:0]  rx_en;
        logic [PIN_N-1:0]  skip;
    } dpg_state_type;

    dpg_state_type st_reg;
    dpg_state_type st_next;

    logic [PIN_N-1:0] digital_mode;
    logic [PIN_N-1:0] latch_all;
    logic [PIN_N-1:0] push_pull;
    logic [PIN_N-1:0] pin_level;
    logic [4:0]       bit_byte;
    logic [2:0]       bit_idx;

    dpg_pin_if #(.WIDTH(PIN_N)) pins ();

    // Pin levels pass two flip-flops before any logic reads them.
    assign pins.raw = pin_in;

    dpg_sync #(
        .WIDTH (PIN_N)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pins    (pins)
    );

    // Per-pin views of the configuration, bit n of each byte on pin n.
    assign digital_mode = {st_reg.second_port_analog_select, st_reg.first_port_analog_select};
    assign latch_all    = {st_reg.second_port_latch, st_reg.first_port_latch};
    assign push_pull    = {st_reg.second_port_drive_type, st_reg.first_port_drive_type} & ~od_force;
    assign pin_level    = pins.level & digital_mode;
    assign bit_byte     = sfr_bit_addr[7:BIT_SEL_LSB];
    assign bit_idx      = sfr_bit_addr[BIT_SEL_LSB-1:0];

    // Register access, read answer and registered pin controls.
    always_comb
    begin
        st_next = st_reg;

        // Byte writes; the address ignores any page selection.
        if (sfr_wr)
        begin
            if (sfr_addr == ADDR_FIRST_LATCH)
            begin
                st_next.first_port_latch = sfr_wdata;
            end
            else if (sfr_addr == ADDR_SECOND_LATCH)
            begin
                st_next.second_port_latch = sfr_wdata;
            end
            else if (sfr_addr == ADDR_FIRST_DRIVE)
            begin
                st_next.first_port_drive_type = sfr_wdata;
            end
            else if (sfr_addr == ADDR_SECOND_DRIVE)
            begin
                st_next.second_port_drive_type = sfr_wdata;
            end
            else if (sfr_addr == ADDR_FIRST_BYPASS)
            begin
                st_next.first_port_crossbar_bypass = sfr_wdata;
            end
            else if (sfr_addr == ADDR_SECOND_BYPASS)
            begin
                st_next.second_port_crossbar_bypass = sfr_wdata;
            end
            else if (sfr_addr == ADDR_FIRST_ANALOG)
            begin
                st_next.first_port_analog_select = sfr_wdata;
            end
            else if (sfr_addr == ADDR_SECOND_ANALOG)
            begin
                st_next.second_port_analog_select = sfr_wdata;
            end
        end

        // Single-bit writes to the data registers land after any byte write.
        if (sfr_bit_wr)
        begin
            if (bit_byte == ADDR_FIRST_LATCH[7:BIT_SEL_LSB])
            begin
                st_next.first_port_latch[bit_idx] = sfr_bit_wdata;
            end
            else if (bit_byte == ADDR_SECOND_LATCH[7:BIT_SEL_LSB])
            begin
                st_next.second_port_latch[bit_idx] = sfr_bit_wdata;
            end
        end

        // Byte reads return pins, or the latch for read-modify-write.
        st_next.rd_data = RD_UNMAPPED;
        st_next.rd_hit  = 1'b0;
        if (sfr_rd)
        begin
            st_next.rd_hit = 1'b1;
            if (sfr_addr == ADDR_FIRST_LATCH)
            begin
                st_next.rd_data = sfr_rmw ? st_reg.first_port_latch : pin_level[PORT_W-1:0];
            end
            else if (sfr_addr == ADDR_SECOND_LATCH)
            begin
                st_next.rd_data = sfr_rmw ? st_reg.second_port_latch : pin_level[PIN_N-1:PORT_W];
            end
            else if (sfr_addr == ADDR_FIRST_DRIVE)
            begin
                st_next.rd_data = st_reg.first_port_drive_type;
            end
            else if (sfr_addr == ADDR_SECOND_DRIVE)
            begin
                st_next.rd_data = st_reg.second_port_drive_type;
            end
            else if (sfr_addr == ADDR_FIRST_BYPASS)
            begin
                st_next.rd_data = st_reg.first_port_crossbar_bypass;
            end
            else if (sfr_addr == ADDR_SECOND_BYPASS)
            begin
                st_next.rd_data = st_reg.second_port_crossbar_bypass;
            end
            else if (sfr_addr == ADDR_FIRST_ANALOG)
            begin
                st_next.rd_data = st_reg.first_port_analog_select;
            end
            else if (sfr_addr == ADDR_SECOND_ANALOG)
            begin
                st_next.rd_data = st_reg.second_port_analog_select;
            end
            else
            begin
                st_next.rd_hit = 1'b0;
            end
        end
        else if (sfr_bit_rd)
        begin
            // Bit reads answer in bit 0; unmapped bit addresses answer zero.
            if (bit_byte == ADDR_FIRST_LATCH[7:BIT_SEL_LSB])
            begin
                st_next.rd_hit     = 1'b1;
                st_next.rd_data[0] = sfr_rmw ? st_reg.first_port_latch[bit_idx] : pin_level[bit_idx];
            end
            else if (bit_byte == ADDR_SECOND_LATCH[7:BIT_SEL_LSB])
            begin
                st_next.rd_hit     = 1'b1;
                st_next.rd_data[0] = sfr_rmw ? st_reg.second_port_latch[bit_idx]
                                             : pin_level[PORT_W + 32'(bit_idx)];
            end
        end

        // Open-drain drives only a low; analog pins drive nothing.
        st_next.drv_out   = latch_all;
        st_next.drv_oe    = digital_mode & (push_pull | ~latch_all);
        st_next.pullup_en = digital_mode;
        st_next.rx_en     = digital_mode;
        st_next.skip      = {st_reg.second_port_crossbar_bypass, st_reg.first_port_crossbar_bypass};
    end

    // State register with documented reset values.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg                             <= '0;
            st_reg.first_port_latch            <= RST_LATCH;
            st_reg.second_port_latch           <= RST_LATCH;
            st_reg.first_port_drive_type       <= RST_DRIVE;
            st_reg.second_port_drive_type      <= RST_DRIVE;
            st_reg.first_port_crossbar_bypass  <= RST_BYPASS;
            st_reg.second_port_crossbar_bypass <= RST_BYPASS;
            st_reg.first_port_analog_select    <= RST_ANALOG;
            st_reg.second_port_analog_select   <= RST_ANALOG;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign sfr_rdata     = st_reg.rd_data;
    assign sfr_hit       = st_reg.rd_hit;
    assign xbar_skip     = st_reg.skip;
    assign pin_out       = st_reg.drv_out;
    assign pin_oe        = st_reg.drv_oe;
    assign pin_pullup_en = st_reg.pullup_en;
    assign pin_rx_en     = st_reg.rx_en;

    // Checks on the register and pin behaviour.
    a_latch_write: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_wr && !sfr_bit_wr && sfr_addr == ADDR_FIRST_LATCH |=> st_reg.first_port_latch == $past(sfr_wdata))
        else $error("Port latch did not take the written byte.");
    a_pin_read: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_rd && !sfr_rmw && sfr_addr == ADDR_SECOND_LATCH |=> sfr_rdata == $past(pin_level[PIN_N-1:PORT_W]))
        else $error("Data read did not return the pin levels.");
    a_rmw_read: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_rd && sfr_rmw && sfr_addr == ADDR_FIRST_LATCH |=> sfr_rdata == $past(st_reg.first_port_latch))
        else $error("Read-modify-write did not return the latch.");
    a_analog_off: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> ((pin_oe | pin_pullup_en | pin_rx_en) & ~$past(digital_mode)) == '0)
        else $error("Analog pin still has a digital function enabled.");
    a_drive_type: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pin_oe == $past(digital_mode & (push_pull | ~latch_all)))
        else $error("Pin enable does not follow the drive type.");
    a_serial_od: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (pin_oe & pin_out & $past(od_force)) == '0)
        else $error("Serial bus pin drove a high level.");
    a_skip_out: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_wr && sfr_addr == ADDR_FIRST_BYPASS |=> ##1 xbar_skip[PORT_W-1:0] == $past(sfr_wdata, 2))
        else $error("Crossbar skip does not follow the register.");
    a_bit_write: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_bit_wr && bit_byte == ADDR_SECOND_LATCH[7:BIT_SEL_LSB]
        |=> st_reg.second_port_latch[$past(bit_idx)] == $past(sfr_bit_wdata))
        else $error("Bit write did not reach the latch bit.");
    a_fixed_decode: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_wr && sfr_addr == ADDR_FIRST_DRIVE |=> st_reg.first_port_drive_type == $past(sfr_wdata))
        else $error("Drive type register missed its write.");
    a_reset_vals: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> st_reg.first_port_latch == RST_LATCH && st_reg.second_port_analog_select == RST_ANALOG
                           && st_reg.second_port_drive_type == RST_DRIVE && st_reg.first_port_crossbar_bypass == RST_BYPASS)
        else $error("Register values after reset are wrong.");
endmodule

// ===== tb/dpg_pin_model.sv
// Behavioural model of the package pins and the outside parts that drive them.
`timescale 1ns/1ns
module dpg_pin_model
    import dpg_pkg::*;
(
    // Clock.
    input  wire logic             clk,
    // Pin drive from the block.
    input  wire logic [PIN_N-1:0] pin_out,
    input  wire logic [PIN_N-1:0] pin_oe,
    input  wire logic [PIN_N-1:0] pin_pullup_en,
    // Outside drivers.
    input  wire logic [PIN_N-1:0] ext_en,
    input  wire logic [PIN_N-1:0] ext_level,
    // Resolved pin level.
    output logic      [PIN_N-1:0] pin_level
);
    logic [PIN_N-1:0] float_pat;

    // A floating pin with no pullup shows a pattern that flips every cycle.
    initial float_pat = 16'h5555;
    always @(posedge clk) float_pat <= ~float_pat;

    // The block's driver wins, then an outside driver, then the weak pullup.
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_level[i]
                         : pin_pullup_en[i] ? 1'b1 : float_pat[i];
        end
    end
endmodule

// ===== tb/dual_port_gpio_config_tb_top.sv
// Self-checking testbench for the dual port GPIO configuration block.
`timescale 1ns/1ns
module dual_port_gpio_config_tb_top
    import dpg_pkg::*;
;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic h;} dpg_row_type;

    logic             clk, sys_rst, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wdata, sfr_bit_wr, sfr_bit_rd, sfr_hit, hit_q;
    logic [7:0]       sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, rd_q;
    logic [PIN_N-1:0] od_force, xbar_skip, pin_in, pin_out, pin_oe, pin_pullup_en, pin_rx_en, ext_en, ext_level;
    int               errors, checked;
    dpg_row_type      rows [9];
    logic [7:0]       rst_addr [4] = '{8'h80, 8'hA4, 8'hD4, 8'hF1};
    logic [7:0]       rst_val  [4] = '{8'hFF, 8'h00, 8'h00, 8'hFF};

    dpg_gpio uut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wdata(sfr_bit_wdata),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_rd(sfr_bit_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .od_force(od_force), .xbar_skip(xbar_skip), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .pin_rx_en(pin_rx_en));

    dpg_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .ext_en(ext_en), .ext_level(ext_level), .pin_level(pin_in));

    // Clock at 25 MHz.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One register access: 0 byte write, 1 byte read, 2 bit write, 3 bit read.
    // A spare edge follows, so a strobe is never raised again in the time step that lowered it.
    task automatic bus(input int op, input logic [7:0] a, input logic [7:0] d, input logic m);
        sfr_addr = a;
        sfr_bit_addr = a;
        sfr_wdata = d;
        sfr_bit_wdata = d[0];
        sfr_rmw = m;
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd} = {op == 0, op == 1, op == 2, op == 3};
        @(posedge clk);
        #1;
        rd_q = sfr_rdata;
        hit_q = sfr_hit;
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd} = 4'h0;
        @(posedge clk);
        #1;
    endtask

    // Lets some clock edges pass, staying just after the edge.
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    // Applies reset for 20 cycles and checks the state it leaves.
    task automatic reset_and_check();
        sys_rst = 1'b1;
        idle(20);
        sys_rst = 1'b0;
        idle(1);
        check(pin_out, 16'hFFFF);
        check(pin_oe, 16'h0000);
        check(pin_pullup_en ^ pin_rx_en, 16'h0000);
        check(xbar_skip, 16'h0000);
        check(pin_rx_en, 16'hFFFF);
        for (int i = 0; i < 4; i++)
        begin
            bus(1, rst_addr[i], 8'h00, 1'b1);
            check({hit_q, rd_q}, {1'b1, rst_val[i]});
        end
        idle(2);
        bus(1, ADDR_FIRST_LATCH, 8'h00, 1'b0);
        check(rd_q, 8'h3C);
        bus(1, ADDR_SECOND_LATCH, 8'h00, 1'b0);
        check(rd_q, 8'hA5);
    endtask

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        #400000;
        errors++;
        end_of_test();
    end

    // Main sequence.
    initial
    begin
        {sys_rst, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wdata, sfr_bit_wr, sfr_bit_rd} = 7'h40;
        {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
        {errors, checked} = {32'd0, 32'd0};
        od_force = 16'h0000;
        ext_en = 16'hFFFF;
        ext_level = 16'hA53C;
        rows = '{'{8'h80, 8'h5A, 8'h5A, 1'b1}, '{8'h90, 8'hC3, 8'hC3, 1'b1}, '{8'hA4, 8'h0F, 8'h0F, 1'b1},
                 '{8'hA5, 8'hF0, 8'hF0, 1'b1}, '{8'hD4, 8'h81, 8'h81, 1'b1}, '{8'hD5, 8'h7E, 8'h7E, 1'b1},
                 '{8'hF1, 8'hFF, 8'hFF, 1'b1}, '{8'hF2, 8'hFF, 8'hFF, 1'b1}, '{8'hA0, 8'h55, 8'h00, 1'b0}};
        @(posedge clk);
        #1;
        reset_and_check();
        // Writes every register, an unmapped place too, and reads each one back, the latches through read-modify-write.
        for (int i = 0; i < 9; i++)
        begin
            bus(0, rows[i].a, rows[i].d, 1'b0);
            bus(1, rows[i].a, 8'h00, 1'b1);
            check({hit_q, rd_q}, {rows[i].h, rows[i].q});
        end
        idle(1);
        check(xbar_skip, 16'h7E81);
        check(pin_out, 16'hC35A);
        check(pin_oe, 16'hFCAF);
        // Serial bus pins drive open-drain whatever the drive type says.
        od_force = 16'hFFFF;
        idle(3);
        check(pin_oe, 16'h3CA5);
        // Driven pins show their low latch bits, the rest show the outside levels, after two sync edges.
        bus(1, ADDR_FIRST_LATCH, 8'h00, 1'b0);
        check(rd_q, 8'h18);
        od_force = 16'h0000;
        // Upper half of the first port goes analog with push-pull still selected.
        bus(0, ADDR_FIRST_DRIVE, 8'hFF, 1'b0);
        bus(0, ADDR_FIRST_ANALOG, 8'h0F, 1'b0);
        idle(4);
        check(pin_oe[7:0], 8'h0F);
        check({pin_pullup_en[7:0], pin_rx_en[7:0]}, 16'h0F0F);
        bus(1, ADDR_FIRST_LATCH, 8'h00, 1'b0);
        check(rd_q, 8'h0A);
        // Bit writes on both latches, a bit read on the second latch, and a bit write off the ports.
        bus(2, 8'h92, 8'h01, 1'b0);
        bus(2, 8'h81, 8'h00, 1'b0);
        bus(2, 8'hA1, 8'h00, 1'b0);
        bus(1, ADDR_SECOND_LATCH, 8'h00, 1'b1);
        check(rd_q, 8'hC7);
        bus(1, ADDR_FIRST_LATCH, 8'h00, 1'b1);
        check(rd_q, 8'h58);
        bus(3, 8'h92, 8'h00, 1'b1);
        check({hit_q, rd_q}, {1'b1, 8'h01});
        bus(1, ADDR_FIRST_DRIVE, 8'h00, 1'b1);
        check(rd_q, 8'hFF);
        idle(1);
        check(pin_out, 16'hC758);
        // A second reset in mid-run restores every register.
        reset_and_check();
        end_of_test();
    end
endmodule
